// ---- design/pio_pkg.sv ----
// constants, types and decoders shared by both ends of the transfer port
// assumes one internal state per clock edge of the 50 MHz clock
//
// Behaviour
// [RULE1] top three bits six mark a transfer
// [RULE2] peripheral decodes six-bit device code field
// [RULE3] peripheral alone interprets low three-bit operation
// [RULE4] five-state fetch, then first and second execute
// [RULE5] each execute cycle lasts six states
// [RULE6] instruction word on data lines with latch strobe
// [RULE7] peripheral latches word on address strobe
// [RULE8] device select strobe low enables exchange
// [RULE9] all lines high: send accumulator, keep it
// [RULE10] zero low: send accumulator, then clear it
// [RULE11] one low: OR input into accumulator
// [RULE12] zero and one low: load accumulator
// [RULE13] two low, one high: relative jump
// [RULE14] one and two low: absolute jump
// [RULE15] skip line low skips next instruction
// [RULE16] skip independent; applied after any jump
// [RULE17] inputs sampled at select and late phase
// [RULE18] output word valid during select and late
// [RULE19] second execute cycle is internal only
// [RULE20] one twelve-bit accumulator word per transfer
package pio_pkg;
  // word and field widths
  localparam int WORD_W = 12;
  localparam int DEV_W = 6;
  localparam int OP_W = 3;
  // field positions, bit 0 of the word is its lsb
  localparam int OPC_LSB = 9;
  localparam int DEV_LSB = 3;
  localparam logic [2:0] XFER_OPCODE = 3'h6;
  // clock and state timing
  localparam int CLK_NS = 20;
  localparam int STATE_NS = 20;
  localparam int STATE_CYCLES = (STATE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] LAST_FETCH_STATE = 3'h4;
  localparam logic [2:0] LAST_EXEC_STATE = 3'h5;
  // strobe placement within the first execute cycle
  localparam logic [2:0] ALS_STATE = 3'h0;
  localparam logic [2:0] DSEL_FIRST = 3'h2;
  localparam logic [2:0] DSEL_LAST = 3'h5;
  localparam logic [2:0] LATE_STATE = 3'h4;
  // reset values
  localparam logic [11:0] WORD_RST = 12'h000;
  localparam logic [2:0] STATE_RST = 3'h0;
  localparam logic [2:0] TYPE_IDLE = 3'h7;

  // processor phases, gray along idle-fetch-a-b
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_FETCH = 2'b01,
    PH_EXEC_A = 2'b11,
    PH_EXEC_B = 2'b10
  } pio_phase_e;

  // transfer kinds chosen by the three type lines
  typedef enum logic [2:0] {
    XT_OUT = 3'h0,
    XT_OUT_CLR = 3'h1,
    XT_OR_IN = 3'h2,
    XT_LOAD_IN = 3'h3,
    XT_REL_JMP = 3'h4,
    XT_ABS_JMP = 3'h5
  } pio_xfer_e;

  // type lines to kind, bit 0 is line zero
  function automatic pio_xfer_e pio_xfer_decode(input logic [2:0] t);
    pio_xfer_e k;
    if (!t[2]) begin
      k = t[1] ? XT_REL_JMP : XT_ABS_JMP;
    end else if (t[1]) begin
      k = t[0] ? XT_OUT : XT_OUT_CLR;
    end else begin
      k = t[0] ? XT_OR_IN : XT_LOAD_IN;
    end
    return k;
  endfunction

  // true when the processor sends the accumulator
  function automatic logic pio_is_output(input logic [2:0] t);
    pio_xfer_e k;
    k = pio_xfer_decode(t);
    return (k == XT_OUT) || (k == XT_OUT_CLR);
  endfunction
endpackage

// ---- design/pio_bus_if.sv ----
// bus between processor end and peripheral end
// assumes pull-ups: undriven data lines read high
`timescale 1ns/10ps
interface pio_bus_if;
  logic [11:0] cpu_data_out; // processor drive value
  logic cpu_data_oe; // processor drives data lines
  logic [11:0] per_data_out; // peripheral drive value
  logic per_data_oe; // peripheral drives data lines
  logic [11:0] mux_data; // resolved data line level
  logic address_latch_strobe; // instruction word valid
  logic device_select_strobe_n; // exchange window, low
  logic late_state_phase; // late part of a state cycle
  logic xfer_type_zero; // transfer type line zero
  logic xfer_type_one; // transfer type line one
  logic xfer_type_two; // transfer type line two
  logic skip_request_n; // skip request, low

  // wire level from the two enables
  assign mux_data = cpu_data_oe ? cpu_data_out : (per_data_oe ? per_data_out : '1);

  modport cpu (
    output cpu_data_out, cpu_data_oe, address_latch_strobe,
    output device_select_strobe_n, late_state_phase,
    input mux_data, xfer_type_zero, xfer_type_one, xfer_type_two, skip_request_n
  );
  modport per (
    output per_data_out, per_data_oe, xfer_type_zero, xfer_type_one,
    output xfer_type_two, skip_request_n,
    input mux_data, address_latch_strobe, device_select_strobe_n, late_state_phase
  );
endinterface

// ---- design/pio_state_cnt.sv ----
// internal state counter of one processor cycle
// assumes the caller holds last_i steady within a cycle
`timescale 1ns/10ps
module pio_state_cnt
  import pio_pkg::*;
(
  input wire logic clk_i, // state clock
  input wire logic rst_n_i, // async reset, low
  input wire logic restart_i, // begin a new cycle at state 0
  input wire logic [2:0] last_i, // index of the final state
  output logic [2:0] state_o, // current state index
  output logic last_o // final state of the cycle
);
  logic [2:0] cnt_q; // state index register

  // wraps at the final state or on restart
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= STATE_RST;
    end else if (restart_i || (cnt_q == last_i)) begin
      cnt_q <= STATE_RST;
    end else begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  assign state_o = cnt_q;
  assign last_o = (cnt_q == last_i);
endmodule

// ---- design/pio_cpu_end.sv ----
// processor end of the programmed transfer port
// assumes the peripheral holds its lines steady while the
// device select strobe is low; one state per clock edge
`timescale 1ns/10ps
module pio_cpu_end
  import pio_pkg::*;
(
  input wire logic MCLK_I, // 50 MHz clock
  input wire logic RESETN_I, // async reset, low
  pio_bus_if.cpu BUS, // bus toward the peripheral
  input wire logic START_I, // begin an instruction
  input wire logic [11:0] INSTR_I, // fetched instruction word
  input wire logic [11:0] ACCUM_I, // accumulator before it
  input wire logic [11:0] PC_I, // next sequential address
  output logic BUSY_O, // instruction in progress
  output logic DONE_O, // instruction finished, pulse
  output logic NOT_XFER_O, // word was no transfer
  output logic SKIPPED_O, // last transfer skipped
  output logic [11:0] ACCUM_O, // accumulator after it
  output logic [11:0] PC_O // program counter after it
);
  import pio_pkg::*;

  // phase and state position
  pio_phase_e phase_q; // current processor phase
  pio_phase_e phase_d; // next processor phase
  logic [2:0] state_idx; // state within the phase
  logic state_last; // final state of the phase
  logic [2:0] last_idx; // final state index by phase
  logic start_ok; // start accepted this edge

  // working registers
  logic [11:0] instr_q; // latched instruction word
  logic [11:0] accum_q; // accumulator
  logic [11:0] pc_q; // program counter
  logic [11:0] out_q; // word on the data lines

  // values sampled in the first execute cycle
  logic [11:0] samp_data_q; // data lines
  logic [2:0] samp_type_q; // type lines, bit 0 is line zero
  logic samp_skip_q; // skip requested

  // status registers
  logic done_q; // finish pulse
  logic not_xfer_q; // rejected word flag
  logic skipped_q; // skip taken flag

  // live decode terms
  logic is_xfer; // latched word is a transfer
  logic in_exec_a; // first execute cycle
  logic dsel_win; // device select window
  logic sample_now; // select and late phase coincide
  logic [2:0] live_type; // type lines as seen now
  pio_xfer_e kind; // sampled transfer kind
  logic [11:0] jump_pc; // pc after a possible jump
  logic [11:0] pc_final; // pc after jump and skip
  logic [11:0] accum_final; // accumulator after it

  assign start_ok = START_I && (phase_q == PH_IDLE);
  assign is_xfer = (instr_q[11:OPC_LSB] == XFER_OPCODE); // RULE1
  assign in_exec_a = (phase_q == PH_EXEC_A);

  // fetch is five states, execute cycles six
  assign last_idx = (phase_q == PH_FETCH) ? LAST_FETCH_STATE : LAST_EXEC_STATE; // RULE4 RULE5

  // shared state counter
  pio_state_cnt pio_state_cnt_inst (
    .clk_i(MCLK_I),
    .rst_n_i(RESETN_I),
    .restart_i(start_ok),
    .last_i(last_idx),
    .state_o(state_idx),
    .last_o(state_last)
  );

  // phase sequencing
  always_comb begin
    phase_d = phase_q;
    unique case (phase_q)
      PH_IDLE: begin
        // wait for the next instruction
        if (START_I) begin
          phase_d = PH_FETCH;
        end
      end
      PH_FETCH: begin
        // decode once the word is in
        if (state_last) begin
          phase_d = is_xfer ? PH_EXEC_A : PH_IDLE; // RULE1 RULE4
        end
      end
      PH_EXEC_A: begin
        // external cycle done
        if (state_last) begin
          phase_d = PH_EXEC_B; // RULE4
        end
      end
      PH_EXEC_B: begin
        // internal cycle done
        if (state_last) begin
          phase_d = PH_IDLE;
        end
      end
    endcase
  end

  // phase register
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      phase_q <= PH_IDLE;
    end else begin
      phase_q <= phase_d;
    end
  end

  // instruction latch, taken with the start
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      instr_q <= WORD_RST;
    end else if (start_ok) begin
      instr_q <= INSTR_I;
    end
  end

  // strobe timing inside the first execute cycle, late phase in every non-idle cycle
  assign dsel_win = in_exec_a && (state_idx >= DSEL_FIRST) && (state_idx <= DSEL_LAST);
  assign BUS.address_latch_strobe = in_exec_a && (state_idx == ALS_STATE); // RULE6
  assign BUS.device_select_strobe_n = !dsel_win; // RULE8 RULE19
  assign BUS.late_state_phase = (phase_q != PH_IDLE) && (state_idx == LATE_STATE);
  assign sample_now = dsel_win && (state_idx == LATE_STATE); // RULE17
  assign live_type = {BUS.xfer_type_two, BUS.xfer_type_one, BUS.xfer_type_zero};

  // data line word: instruction for the latch strobe, else accumulator
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      out_q <= WORD_RST;
    end else if ((phase_q == PH_FETCH) && state_last) begin
      out_q <= instr_q; // RULE6
    end else begin
      out_q <= accum_q; // RULE20
    end
  end

  // drive only at the latch strobe or for an output transfer
  assign BUS.cpu_data_out = out_q;
  assign BUS.cpu_data_oe = BUS.address_latch_strobe || (sample_now && pio_is_output(live_type)); // RULE6 RULE18

  // sample the peripheral's lines at select and late phase
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      samp_data_q <= WORD_RST;
      samp_type_q <= TYPE_IDLE;
      samp_skip_q <= 1'b0;
    end else if (sample_now) begin
      samp_data_q <= BUS.mux_data; // RULE17
      samp_type_q <= live_type; // RULE17
      samp_skip_q <= !BUS.skip_request_n; // RULE15 RULE17
    end
  end

  // results of the second execute cycle
  always_comb begin
    kind = pio_xfer_decode(samp_type_q);
    jump_pc = pc_q;
    accum_final = accum_q;
    unique case (kind)
      XT_OUT: begin
        // accumulator kept
        accum_final = accum_q; // RULE9
      end
      XT_OUT_CLR: begin
        // sent, then cleared
        accum_final = WORD_RST; // RULE10
      end
      XT_OR_IN: begin
        // inclusive or of the input
        accum_final = accum_q | samp_data_q; // RULE11
      end
      XT_LOAD_IN: begin
        // input replaces accumulator
        accum_final = samp_data_q; // RULE12
      end
      XT_REL_JMP: begin
        // relative jump
        jump_pc = pc_q + samp_data_q; // RULE13
      end
      XT_ABS_JMP: begin
        // absolute jump
        jump_pc = samp_data_q; // RULE14
      end
      default: begin
        // unused codes leave both alone
        accum_final = accum_q;
      end
    endcase
    // skip stacks on top of any jump
    pc_final = samp_skip_q ? (jump_pc + 12'h001) : jump_pc; // RULE15 RULE16
  end

  // accumulator and program counter
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      accum_q <= WORD_RST;
      pc_q <= WORD_RST;
    end else if (start_ok) begin
      accum_q <= ACCUM_I;
      pc_q <= PC_I;
    end else if ((phase_q == PH_EXEC_B) && state_last) begin
      accum_q <= accum_final; // RULE19 RULE20
      pc_q <= pc_final; // RULE19
    end
  end

  // finish pulse and status flags
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      done_q <= 1'b0;
      not_xfer_q <= 1'b0;
      skipped_q <= 1'b0;
    end else begin
      done_q <= state_last && ((phase_q == PH_EXEC_B) || ((phase_q == PH_FETCH) && !is_xfer));
      if ((phase_q == PH_FETCH) && state_last) begin
        not_xfer_q <= !is_xfer; // RULE1
      end
      if ((phase_q == PH_EXEC_B) && state_last) begin
        skipped_q <= samp_skip_q; // RULE15
      end
    end
  end

  // user-side outputs
  assign BUSY_O = (phase_q != PH_IDLE);
  assign DONE_O = done_q;
  assign NOT_XFER_O = not_xfer_q;
  assign SKIPPED_O = skipped_q;
  assign ACCUM_O = accum_q;
  assign PC_O = pc_q;
endmodule

// ---- design/pio_per_end.sv ----
// peripheral end of the programmed transfer port
// assumes the processor end drives the strobes from reset
`timescale 1ns/10ps
module pio_per_end
  import pio_pkg::*;
(
  input wire logic MCLK_I, // 50 MHz clock
  input wire logic RESETN_I, // async reset, low
  pio_bus_if.per BUS, // bus toward the processor
  input wire logic [5:0] DEV_CODE_I, // own device code
  input wire logic [2:0] XFER_TYPE_I, // type lines, bit 0 line zero
  input wire logic SKIP_I, // request a skip, high
  input wire logic [11:0] IN_WORD_I, // word offered to the processor
  output logic SELECTED_O, // latched word addresses us
  output logic [2:0] OP_O, // operation field
  output logic [11:0] OUT_WORD_O, // accumulator received
  output logic OUT_STB_O, // word received, pulse
  output logic IN_STB_O // word taken or jump done, pulse
);
  import pio_pkg::*;

  logic [11:0] addr_q; // external address register
  logic [11:0] in_word_q; // offered word, frozen in window
  logic [11:0] out_word_q; // received accumulator
  logic out_stb_q; // receive pulse
  logic in_stb_q; // offer taken pulse
  logic sel; // this device addressed
  logic active; // addressed and select low
  logic late_hit; // select and late phase coincide
  logic sends_in; // transfer moves a word to the processor

  // latch the instruction word on the address strobe
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      addr_q <= WORD_RST;
    end else if (BUS.address_latch_strobe) begin
      addr_q <= BUS.mux_data; // RULE7
    end
  end

  // device code match on a transfer word only
  assign sel = (addr_q[11:OPC_LSB] == XFER_OPCODE) && (addr_q[OPC_LSB-1:DEV_LSB] == DEV_CODE_I); // RULE2
  assign active = sel && !BUS.device_select_strobe_n; // RULE8
  assign late_hit = active && BUS.late_state_phase;
  assign sends_in = !pio_is_output(XFER_TYPE_I);

  // type and skip lines: idle high unless selected
  assign BUS.xfer_type_zero = active ? XFER_TYPE_I[0] : TYPE_IDLE[0]; // RULE9 RULE10 RULE11
  assign BUS.xfer_type_one = active ? XFER_TYPE_I[1] : TYPE_IDLE[1]; // RULE12 RULE13 RULE14
  assign BUS.xfer_type_two = active ? XFER_TYPE_I[2] : TYPE_IDLE[2];
  assign BUS.skip_request_n = !(active && SKIP_I); // RULE15

  // freeze the offered word so it holds through the window
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      in_word_q <= WORD_RST;
    end else if (!active) begin
      in_word_q <= IN_WORD_I; // RULE17
    end
  end

  // drive data only for input and jump kinds
  assign BUS.per_data_out = in_word_q;
  assign BUS.per_data_oe = active && sends_in; // RULE17

  // capture the accumulator and mark each exchange
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      out_word_q <= WORD_RST;
      out_stb_q <= 1'b0;
      in_stb_q <= 1'b0;
    end else begin
      out_stb_q <= late_hit && !sends_in;
      in_stb_q <= late_hit && sends_in;
      if (late_hit && !sends_in) begin
        out_word_q <= BUS.mux_data; // RULE9 RULE10
      end
    end
  end

  // user-side outputs; operation meaning is left to the user
  assign SELECTED_O = sel;
  assign OP_O = addr_q[OP_W-1:0]; // RULE3
  assign OUT_WORD_O = out_word_q;
  assign OUT_STB_O = out_stb_q;
  assign IN_STB_O = in_stb_q;
endmodule

// ---- dv/pio_asserts.sv ----
// concurrent checks on the bus between processor end and peripheral end
// assumes instantiation beside the interface; one clock domain
`timescale 1ns/10ps
module pio_asserts (
  input wire logic MCLK_I, // clock
  input wire logic RESETN_I, // async reset, low
  input wire logic [11:0] mux_data, // resolved data lines
  input wire logic cpu_data_oe, // processor drives lines
  input wire logic address_latch_strobe, // word valid
  input wire logic device_select_strobe_n, // exchange window, low
  input wire logic late_state_phase, // late state part
  input wire logic xfer_type_one, // type line one
  input wire logic xfer_type_two // type line two
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RESETN_I);
  // transfer word on the lines with the latch strobe
  a_word_on_strobe: assert property (address_latch_strobe |-> cpu_data_oe && mux_data[11:9] == 3'h6)
    else $error("latch strobe without transfer word");
  // fetch ends with its late state just before the strobe
  a_fetch_before: assert property (address_latch_strobe |-> $past(late_state_phase))
    else $error("latch strobe not after fetch");
  // select falls two states after the strobe
  a_strobe_select: assert property (address_latch_strobe |=> device_select_strobe_n ##1 $fell(device_select_strobe_n))
    else $error("select not two states after strobe");
  // select stays low four states
  a_select_width: assert property ($fell(device_select_strobe_n) |-> !device_select_strobe_n[*4] ##1 device_select_strobe_n)
    else $error("select window width wrong");
  // late phase falls inside the select window
  a_late_in_select: assert property ($fell(device_select_strobe_n) |-> ##2 late_state_phase)
    else $error("late phase missing in window");
  // first execute cycle is six states long
  a_exec_a_len: assert property (address_latch_strobe |-> ##6 $rose(device_select_strobe_n))
    else $error("first execute length wrong");
  // second execute cycle late state ten states after the strobe
  a_exec_b_len: assert property (address_latch_strobe |-> ##10 late_state_phase && device_select_strobe_n)
    else $error("second execute length wrong");
  // processor drives the accumulator for output kinds
  a_out_drive: assert property (!device_select_strobe_n && late_state_phase && xfer_type_one && xfer_type_two
    |-> cpu_data_oe)
    else $error("output word not driven");
  // processor releases lines for input and jump kinds
  a_in_release: assert property (!device_select_strobe_n && late_state_phase && !(xfer_type_one && xfer_type_two)
    |-> !cpu_data_oe)
    else $error("processor drives during input");
  // second execute cycle shows no select, latch strobe or processor drive
  a_exec_b_quiet: assert property ($rose(device_select_strobe_n)
    |-> (device_select_strobe_n && !address_latch_strobe && !cpu_data_oe)[*6])
    else $error("bus activity in second execute");
endmodule

// ---- dv/programmed_io_transfer_port_tb.sv ----
// testbench joining processor end and peripheral end over the bus
// assumes the design package and interface compiled before it
`timescale 1ns/10ps
module programmed_io_transfer_port_tb;
  import pio_pkg::*;
  localparam logic [5:0] MY_DEV = 6'h2A; // own device code
  logic mclk = 1'b0; // clock
  logic resetn = 1'b0; // reset, low
  logic start = 1'b0; // begin instruction
  logic [11:0] instr = 12'h000; // instruction word
  logic [11:0] accum_in = 12'h000; // accumulator before
  logic [11:0] pc_in = 12'h000; // next address
  logic [2:0] ty = 3'h7; // type lines offered
  logic skip = 1'b0; // skip request
  logic [11:0] in_word = 12'h000; // word offered
  logic busy, done, not_xfer, skipped, selected, out_stb, in_stb; // design flags
  logic [11:0] accum_out, pc_out, out_word; // design results
  logic [11:0] als_word, bus_word; // words seen on the lines
  logic [2:0] op; // operation field
  int fail_count = 0; // mismatches
  int n_checks = 0; // comparisons
  int out_cnt = 0; // received pulses
  int in_cnt = 0; // taken pulses
  pio_bus_if pio_bus_if_inst ();
  pio_cpu_end pio_cpu_end_inst (.MCLK_I(mclk), .RESETN_I(resetn), .BUS(pio_bus_if_inst), .START_I(start),
    .INSTR_I(instr), .ACCUM_I(accum_in), .PC_I(pc_in), .BUSY_O(busy), .DONE_O(done), .NOT_XFER_O(not_xfer),
    .SKIPPED_O(skipped), .ACCUM_O(accum_out), .PC_O(pc_out));
  pio_per_end pio_per_end_inst (.MCLK_I(mclk), .RESETN_I(resetn), .BUS(pio_bus_if_inst), .DEV_CODE_I(MY_DEV),
    .XFER_TYPE_I(ty), .SKIP_I(skip), .IN_WORD_I(in_word), .SELECTED_O(selected), .OP_O(op),
    .OUT_WORD_O(out_word), .OUT_STB_O(out_stb), .IN_STB_O(in_stb));
  pio_asserts pio_asserts_inst (.MCLK_I(mclk), .RESETN_I(resetn), .mux_data(pio_bus_if_inst.mux_data),
    .cpu_data_oe(pio_bus_if_inst.cpu_data_oe), .address_latch_strobe(pio_bus_if_inst.address_latch_strobe),
    .device_select_strobe_n(pio_bus_if_inst.device_select_strobe_n),
    .late_state_phase(pio_bus_if_inst.late_state_phase), .xfer_type_one(pio_bus_if_inst.xfer_type_one),
    .xfer_type_two(pio_bus_if_inst.xfer_type_two));

  // free running clock
  initial begin
    forever #10 mclk = ~mclk;
  end

  // capture words on the lines and count pulses
  always @(posedge mclk) begin
    if (pio_bus_if_inst.address_latch_strobe) begin
      als_word <= pio_bus_if_inst.mux_data;
    end
    if (!pio_bus_if_inst.device_select_strobe_n && pio_bus_if_inst.late_state_phase) begin
      bus_word <= pio_bus_if_inst.mux_data;
    end
    if (out_stb) begin
      out_cnt <= out_cnt + 1;
    end
    if (in_stb) begin
      in_cnt <= in_cnt + 1;
    end
  end

  // compare one value
  task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic results();
    if (fail_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // one instruction through both ends, expectations from the type table
  task automatic run(input logic [11:0] ins, input logic [2:0] t, input logic sk);
    logic xf;
    logic sel;
    logic outk;
    logic [11:0] eac;
    logic [11:0] epc;
    int n;
    int oc;
    int ic;
    xf = (ins[11:9] == 3'h6);
    sel = xf && (ins[8:3] == MY_DEV);
    outk = !sel || (t[2] && t[1]);
    eac = accum_in;
    epc = pc_in;
    if (sel) begin
      case ({t[2], t[1]})
        2'b11: eac = t[0] ? accum_in : 12'h000;
        2'b10: eac = t[0] ? (accum_in | in_word) : in_word;
        2'b01: epc = pc_in + in_word;
        default: epc = in_word;
      endcase
      epc = epc + 12'(sk);
    end
    oc = out_cnt;
    ic = in_cnt;
    n = 0;
    @(negedge mclk);
    start = 1'b1;
    instr = ins;
    ty = t;
    skip = sk;
    @(negedge mclk);
    start = 1'b0;
    while (done !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 40) begin
      fail_count++;
      results();
    end
    chk("cycles", 12'(n), xf ? 12'h011 : 12'h005);
    chk("not transfer", 12'(not_xfer), 12'(!xf));
    chk("accumulator", accum_out, eac);
    chk("pc", pc_out, epc);
    chk("skipped", 12'(skipped), 12'(sel && sk));
    chk("out pulses", 12'(out_cnt - oc), 12'(sel && outk));
    chk("in pulses", 12'(in_cnt - ic), 12'(sel && !outk));
    if (xf) begin
      chk("latched word", als_word, ins);
      chk("selected", 12'(selected), 12'(sel));
      chk("bus word", bus_word, outk ? accum_in : in_word);
    end
    if (sel) begin
      chk("op field", 12'(op), 12'(ins[2:0]));
    end
    if (sel && outk) begin
      chk("out word", out_word, accum_in);
    end
  endtask

  // main sequence
  initial begin
    repeat (6) @(negedge mclk);
    resetn = 1'b1;
    pc_in = 12'hFFE;
    for (int i = 0; i < 16; i++) begin
      accum_in = 12'h5A3 ^ 12'(i);
      in_word = 12'h0C6 + 12'(i);
      run({3'h6, MY_DEV, i[2:0]}, i[2:0], i[3]);
    end
    run({3'h6, MY_DEV ^ 6'h3F, 3'h5}, 3'h0, 1'b1);
    run(12'h5A3, 3'h1, 1'b1);
    @(negedge mclk);
    start = 1'b1;
    instr = {3'h6, MY_DEV, 3'h0};
    @(negedge mclk);
    start = 1'b0;
    repeat (8) @(negedge mclk);
    resetn = 1'b0;
    @(negedge mclk);
    chk("busy in reset", 12'(busy), 12'h000);
    resetn = 1'b1;
    run({3'h6, MY_DEV, 3'h2}, 3'h3, 1'b0);
    results();
  end
endmodule
